// file: verilog/host_bus_interface.sv
`include "host_bus_defs.svh"
`default_nettype none

module host_bus_interface #(
  parameter int N_COUNTERS = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic bus_style_select,
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic [`DATA_W-1:0] data_in,
  output logic [`DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic sel_n,
  input wire logic rd_n,
  input wire logic wr_n,
  output logic transfer_acknowledge,
  output logic transfer_acknowledge_oe,
  input wire logic irq_request,
  output logic host_interrupt_line,
  input wire logic one_second_latch_pulse,
  input wire logic [N_COUNTERS*`DATA_W-1:0] counter_values,
  output logic shadow_latch_enable,
  output logic interrupt_sense_invert
);

  host_bus_pkg::pins_t raw_pins;
  host_bus_pkg::pins_t pins;
  host_bus_pkg::request_t req;
  host_bus_pkg::request_t raw_req;
  host_bus_pkg::state_t state;
  host_bus_pkg::state_t next_state;
  logic [`DATA_W-1:0] ctrl;
  logic [`DATA_W-1:0] shadow [N_COUNTERS];
  logic [`DATA_W-1:0] next_read_data;
  logic pulse_seen;
  logic pulse_rise;
  logic start;

  // Bus style decides how select and strobes combine into one request.
  function automatic host_bus_pkg::request_t decode(input host_bus_pkg::pins_t p);
    host_bus_pkg::request_t r;
    if (p.style) begin
      r.active = !p.sel_n;
      r.is_read = p.rd_n;
    end else begin
      r.active = !p.sel_n && (!p.rd_n || !p.wr_n);
      r.is_read = !p.rd_n;
    end
    return r;
  endfunction

  // Pins enter through a synchroniser so each strobe yields one access.
  assign raw_pins = '{style: bus_style_select, sel_n: sel_n, rd_n: rd_n, wr_n: wr_n,
                      pulse: one_second_latch_pulse};

  pin_sync #(
    .WIDTH(5),
    .RESET_VALUE(5'h0E)
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .d(raw_pins),
    .q(pins)
  );

  assign req = decode(pins);
  assign raw_req = decode(raw_pins);
  assign start = (state == host_bus_pkg::ST_IDLE) && req.active;

  // Read multiplexer over control and shadow registers; holes read as zero.
  always_comb begin
    next_read_data = `UNMAPPED_DATA;
    if (addr == `CTRL_ADDR) begin
      next_read_data = ctrl;
    end
    for (int i = 0; i < N_COUNTERS; i++) begin
      // The loop index is cut to the address width so the sum stays twelve bits wide.
      if (addr == `SHADOW_BASE + i[`ADDR_W-1:0]) begin
        next_read_data = shadow[i];
      end
    end
  end

  // An access completes on the cycle it is seen and then waits for release.
  always_comb begin
    case (state)
      host_bus_pkg::ST_IDLE: next_state = req.active ? host_bus_pkg::ST_DONE : host_bus_pkg::ST_IDLE;
      host_bus_pkg::ST_DONE: next_state = req.active ? host_bus_pkg::ST_DONE : host_bus_pkg::ST_IDLE;
      default: next_state = host_bus_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= host_bus_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Control register write; only the first cycle of an access writes.
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl <= `CTRL_RESET;
    end else if (start && !req.is_read && addr == `CTRL_ADDR) begin
      ctrl <= data_in;
    end
  end

  // Read data is captured once and held until the strobe goes away.
  always_ff @(posedge clk) begin
    if (reset) begin
      data_out <= `UNMAPPED_DATA;
      data_oe <= 1'b0;
    end else begin
      if (start && req.is_read) begin
        data_out <= next_read_data;
      end
      data_oe <= (next_state == host_bus_pkg::ST_DONE) && req.is_read;
    end
  end

  // Ready drops as soon as a strobe is seen, since the answer needs the synchroniser delay.
  always_ff @(posedge clk) begin
    if (reset) begin
      transfer_acknowledge <= 1'b1;
      transfer_acknowledge_oe <= 1'b0;
    end else if (pins.style) begin
      transfer_acknowledge <= 1'b0;
      transfer_acknowledge_oe <= (next_state == host_bus_pkg::ST_DONE);
    end else begin
      transfer_acknowledge <= !(raw_req.active && state == host_bus_pkg::ST_IDLE);
      transfer_acknowledge_oe <= 1'b1;
    end
  end

  // Rising edge of the synchronised pulse, looked at after the second stage only.
  always_ff @(posedge clk) begin
    if (reset) begin
      pulse_seen <= 1'b0;
    end else begin
      pulse_seen <= pins.pulse;
    end
  end

  assign pulse_rise = pins.pulse && !pulse_seen;

  // Counters are copied as a set so software sees one consistent second.
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < N_COUNTERS; i++) begin
        shadow[i] <= `UNMAPPED_DATA;
      end
    end else if (pulse_rise && ctrl[`CTRL_LATCH_BIT]) begin
      for (int i = 0; i < N_COUNTERS; i++) begin
        shadow[i] <= counter_values[i*`DATA_W +: `DATA_W];
      end
    end
  end

  // Interrupt sense: high-active in strobe style, low-active in line style, both reversed while the control invert bit is set.
  always_ff @(posedge clk) begin
    if (reset) begin
      host_interrupt_line <= 1'b0;
      shadow_latch_enable <= 1'b0;
      interrupt_sense_invert <= 1'b0;
    end else begin
      host_interrupt_line <= irq_request ^ pins.style ^ ctrl[`CTRL_INVERT_BIT];
      shadow_latch_enable <= ctrl[`CTRL_LATCH_BIT];
      interrupt_sense_invert <= ctrl[`CTRL_INVERT_BIT];
    end
  end

  AST_CTRL_WRITE: assert property (@(posedge clk) disable iff (reset)
    start && !req.is_read && addr == `CTRL_ADDR |=> ctrl == $past(data_in))
    else $error("control write not stored");

  AST_NO_SELECT_NO_WRITE: assert property (@(posedge clk) disable iff (reset)
    pins.sel_n |=> $stable(ctrl))
    else $error("control changed without select");

  AST_READ_DATA: assert property (@(posedge clk) disable iff (reset)
    start && req.is_read |=> data_oe && data_out == $past(next_read_data))
    else $error("read data not driven");

  AST_LATCH_GATED: assert property (@(posedge clk) disable iff (reset)
    pulse_rise && !ctrl[`CTRL_LATCH_BIT] |=> $stable(shadow[0]))
    else $error("shadow latched while disabled");

  AST_LATCH_TAKES: assert property (@(posedge clk) disable iff (reset)
    pulse_rise && ctrl[`CTRL_LATCH_BIT] |=> shadow[0] == $past(counter_values[`DATA_W-1:0]))
    else $error("shadow not latched");

  AST_ONE_LATCH: assert property (@(posedge clk) disable iff (reset)
    pulse_rise |=> !pulse_rise)
    else $error("double latch event");

  AST_IRQ_SENSE: assert property (@(posedge clk) disable iff (reset)
    ##1 host_interrupt_line == $past(irq_request ^ pins.style ^ ctrl[`CTRL_INVERT_BIT]))
    else $error("interrupt sense wrong");

  AST_ACK_RELEASE: assert property (@(posedge clk) disable iff (reset)
    pins.style && state == host_bus_pkg::ST_DONE && !req.active |=> !transfer_acknowledge_oe)
    else $error("acknowledge not released");

  AST_READY_DONE: assert property (@(posedge clk) disable iff (reset)
    !pins.style && state == host_bus_pkg::ST_DONE |=> transfer_acknowledge && transfer_acknowledge_oe)
    else $error("ready low after completion");

  AST_LINE_WRITE: assert property (@(posedge clk) disable iff (reset)
    pins.style && start && !pins.rd_n |=> !data_oe)
    else $error("bus driven on write");

endmodule : host_bus_interface

`default_nettype wire

// file: verilog/host_bus_defs.svh
`ifndef HOST_BUS_DEFS_SVH
`define HOST_BUS_DEFS_SVH

// Register address and data widths of the host port.
`define ADDR_W 12
`define DATA_W 8

// Control register location, its reset value and its two bits.
`define CTRL_ADDR 12'h006
`define CTRL_RESET 8'h00
`define CTRL_LATCH_BIT 3
`define CTRL_INVERT_BIT 4

// First address of the shadow register bank.
`define SHADOW_BASE 12'h010

// Value returned for an address that holds no register.
`define UNMAPPED_DATA 8'h00

// Depth of every pin synchroniser.
`define SYNC_STAGES 2

`endif

// file: verilog/host_bus_pkg.sv
`default_nettype none

package host_bus_pkg;

  // Host control pins that cross into the system clock together.
  typedef struct packed {
    logic style;
    logic sel_n;
    logic rd_n;
    logic wr_n;
    logic pulse;
  } pins_t;

  // Decoded host request.
  typedef struct packed {
    logic active;
    logic is_read;
  } request_t;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_DONE
  } state_t;

endpackage : host_bus_pkg

`default_nettype wire

// file: verilog/pin_sync.sv
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  // Two flops; the first is read only by the second to contain metastability.
  always_ff @(posedge clk) begin
    if (reset) begin
      meta <= RESET_VALUE;
      q <= RESET_VALUE;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : pin_sync

`default_nettype wire

// file: verification/host_model.sv
`default_nettype none

module host_model (
  input wire logic clk,
  input wire logic style,
  input wire logic [7:0] data_out,
  input wire logic transfer_acknowledge,
  input wire logic transfer_acknowledge_oe,
  output logic [11:0] addr,
  output logic [7:0] data_in,
  output logic sel_n,
  output logic rd_n,
  output logic wr_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // The bus rests deselected until a cycle is asked for.
  initial begin
    sel_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 12'h000;
    data_in = 8'h00;
  end

  // One register cycle; it waits for the answer so wait states are honoured.
  task automatic access(input logic wr, input logic [11:0] a, input logic [7:0] wd, input logic skip,
                        output logic [7:0] rd, output logic ok);
    int n;
    logic low;
    n = 0;
    low = 1'b0;
    @(negedge clk);
    addr = a;
    sel_n = skip;
    rd_n = style ? !wr : wr;
    wr_n = style ? 1'b1 : !wr;
    if (wr) data_in = wd;
    do begin
      @(negedge clk);
      n++;
      low |= !transfer_acknowledge;
      ok = style ? (transfer_acknowledge_oe && !transfer_acknowledge) : (low && transfer_acknowledge);
    end while (n < 12 && !ok);
    // Read data is taken at the same sample that saw the answer, away from the launching edge.
    rd = data_out;
    @(negedge clk);
    sel_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    data_in = ~data_in; // Released data must not look valid.
    repeat (4) @(negedge clk);
  endtask
endmodule // host_model

`default_nettype wire

// file: verification/test_host_bus_interface.sv
`default_nettype none

module test_host_bus_interface;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic reset = 1'b1;
  logic style = 1'b0;
  logic irq = 1'b0;
  logic pulse = 1'b0;
  logic [63:0] counters = 64'h8877665544332211;
  logic [11:0] addr;
  logic [7:0] data_in, data_out, rd;
  logic data_oe, sel_n, rd_n, wr_n, ack, ack_oe, int_line, latch_en, inv, ok;
  int failures = 0;
  int checks = 0;
  int cycles = 0;

  host_bus_interface host_bus_interface_inst (.clk(clk), .reset(reset), .bus_style_select(style),
    .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .sel_n(sel_n), .rd_n(rd_n),
    .wr_n(wr_n), .transfer_acknowledge(ack), .transfer_acknowledge_oe(ack_oe), .irq_request(irq),
    .host_interrupt_line(int_line), .one_second_latch_pulse(pulse), .counter_values(counters),
    .shadow_latch_enable(latch_en), .interrupt_sense_invert(inv));

  host_model host_model_inst (.clk(clk), .style(style), .data_out(data_out), .transfer_acknowledge(ack),
    .transfer_acknowledge_oe(ack_oe), .addr(addr), .data_in(data_in), .sel_n(sel_n), .rd_n(rd_n), .wr_n(wr_n));

  // Clock and a cycle ceiling so a hung handshake still ends the run.
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      end_of_test();
    end
  end

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // A lost handshake is counted as a mismatch.
  task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] wd, input logic skip);
    host_model_inst.access(wr, a, wd, skip, rd, ok);
    if (!skip) chk("handshake", 8'h01, {7'h00, ok});
  endtask

  task automatic fire_pulse();
    @(negedge clk) pulse = 1'b1;
    repeat (4) @(negedge clk);
    pulse = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  // Outputs while reset is held, then one edge after release, when ready is driven high in strobe style.
  task automatic test_reset_values();
    chk("in reset", 8'h08, {2'h0, data_oe, ack_oe, ack, int_line, latch_en, inv});
    chk("reset data", 8'h00, data_out);
    reset = 1'b0;
    @(negedge clk);
    chk("oe", 8'h03, {5'h00, data_oe, ack_oe, ack});
    chk("enables", 8'h00, {6'h00, latch_en, inv});
  endtask

  // Pulses are ignored until the enable bit is set.
  task automatic test_latch();
    fire_pulse();
    bus(1'b0, 12'h010, 8'h00, 1'b0);
    chk("shadow off", 8'h00, rd);
    bus(1'b1, 12'h006, 8'h08, 1'b0);
    chk("latch_en", 8'h01, {7'h00, latch_en});
    fire_pulse();
    bus(1'b0, 12'h010, 8'h00, 1'b0);
    chk("shadow 0", 8'h11, rd);
    bus(1'b0, 12'h017, 8'h00, 1'b0);
    chk("shadow 7", 8'h88, rd);
  endtask

  task automatic test_select();
    bus(1'b1, 12'h006, 8'h00, 1'b1);
    bus(1'b0, 12'h006, 8'h00, 1'b0);
    chk("ctrl", 8'h08, rd);
    bus(1'b0, 12'h020, 8'h00, 1'b0);
    chk("unmapped", 8'h00, rd);
  endtask

  task automatic test_irq_strobe();
    irq = 1'b1;
    repeat (3) @(negedge clk);
    chk("int high", 8'h01, {7'h00, int_line});
    bus(1'b1, 12'h006, 8'h18, 1'b0);
    chk("int inv", 8'h02, {6'h00, inv, int_line});
  endtask

  // Direction-line style: reads and writes use the single line and the acknowledge.
  task automatic test_line_style();
    style = 1'b1;
    repeat (4) @(negedge clk);
    chk("int line", 8'h01, {7'h00, int_line});
    bus(1'b1, 12'h006, 8'h00, 1'b0);
    bus(1'b0, 12'h006, 8'h00, 1'b0);
    chk("ctrl line", 8'h00, rd);
    chk("int clr", 8'h00, {7'h00, int_line});
    chk("ack rel", 8'h00, {6'h00, ack_oe, data_oe});
  endtask

  task automatic end_of_test();
    $display("failures %0d checks %0d", failures, checks);
    if (failures == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Main sequence after a five-cycle reset.
  initial begin
    repeat (5) @(negedge clk);
    test_reset_values();
    test_latch();
    test_select();
    test_irq_strobe();
    test_line_style();
    end_of_test();
  end
endmodule // test_host_bus_interface

`default_nettype wire
